/* design/utd_tx_cfg.sv */
// USB2 transmit drive configuration registers and de-emphasis pattern logic
`timescale 1ns/1ps

// How it works
// R1 - De-emphasis needs both a level and a duration set
// R2 - Repeated bits send at reduced swing
// R3 - Alternating bits send at full swing
// R4 - Transmit control register at offset 0x08
// R5 - Bit 6 picks FS edge time, resets 1
// R6 - Bits 5:4 pick HS slew, reset 10
// R7 - Bits 2:0 pick HS swing, reset 010
// R8 - Swing applies to terminated HS only
// R9 - Companion field sets de-emphasis level dB
// R10 - Two-bit field sets de-emphasis duration
// R11 - Reserved bits read zero, ignore writes
// R12 - Host avoids reserved and undocumented codes; the bench sets reserved bits on some writes
module utd_tx_cfg #(
  parameter logic [6:0] I2C_ADDR = 7'h2a // Bus address, arbitrary default
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oen_o,
  input wire logic hs_active_i,
  input wire logic hs_bit_i,
  input wire logic hs_bit_valid_i,
  output logic fs_fast_edge_o,
  output logic [1:0] hs_slew_o,
  output logic [2:0] hs_swing_o,
  output logic [2:0] deemph_lvl_o,
  output logic [1:0] deemph_dur_o,
  output logic tx_full_o,
  output logic tx_reduce_o,
  output logic [2:0] tx_drop_db_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] ctl1_reg; // De-emphasis level and duration
  logic [7:0] ctl2_reg; // Slew and swing selections
  logic prev_bit_reg; // Last bit sent in this burst
  logic have_prev_reg; // A previous bit exists in this burst
  logic full_reg; // Current bit goes out at full swing
  logic reduce_reg; // Current bit is a repeat at reduced swing
  logic [2:0] drop_reg; // Swing reduction applied, in dB

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic wr; // One-cycle write strobe
  logic [7:0] waddr; // Write offset
  logic [7:0] wdata; // Write data
  logic [7:0] ptr; // Current read offset
  logic [7:0] rdata; // Read data for current offset

  // Serial target turns bus cycles into strobes
  utd_i2c_tgt #(
    .ADDR(I2C_ADDR)
  ) u_tgt (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .rdata_i(rdata),
    .sda_oen_o(sda_oen_o),
    .wr_o(wr),
    .waddr_o(waddr),
    .wdata_o(wdata),
    .ptr_o(ptr)
  );

  // ----------------------------------------------------------------
  // Decode and read selection
  // ----------------------------------------------------------------
  wire wr_ctl1 = wr && (waddr == utd_pkg::OFS_CTL1);
  wire wr_ctl2 = wr && (waddr == utd_pkg::OFS_CTL2); // R4
  // Masks keep the reserved positions at zero in storage itself
  wire [7:0] ctl1_next = wr_ctl1 ? (wdata & utd_pkg::CTL1_MASK) : ctl1_reg; // R11
  wire [7:0] ctl2_next = wr_ctl2 ? (wdata & utd_pkg::CTL2_MASK) : ctl2_reg; // R11
  // Offsets outside the bank read as zero and ignore writes
  wire [7:0] rd_ctl1 = (ptr == utd_pkg::OFS_CTL1) ? ctl1_reg : 8'h00;
  wire [7:0] rd_ctl2 = (ptr == utd_pkg::OFS_CTL2) ? ctl2_reg : 8'h00; // R4
  assign rdata = rd_ctl1 | rd_ctl2;

  // Configuration registers, cleared to documented values by reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctl1_reg <= utd_pkg::CTL1_RST; // R9 R10
      ctl2_reg <= utd_pkg::CTL2_RST; // R5 R6 R7
    end else begin
      ctl1_reg <= ctl1_next;
      ctl2_reg <= ctl2_next;
    end
  end

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  // Reserved codes pass through unchanged; the analog side must not rely
  // on them, so no clamping is spent here
  assign fs_fast_edge_o = ctl2_reg[utd_pkg::FS_EDGE_BIT]; // R5
  assign hs_slew_o = ctl2_reg[utd_pkg::HS_SLEW_LSB +: 2]; // R6
  assign hs_swing_o = ctl2_reg[utd_pkg::SWING_LSB +: 3]; // R7
  assign deemph_lvl_o = ctl1_reg[utd_pkg::LVL_LSB +: 3]; // R9
  assign deemph_dur_o = ctl1_reg[utd_pkg::DUR_LSB +: 2]; // R10

  // ----------------------------------------------------------------
  // De-emphasis pattern detection
  // ----------------------------------------------------------------
  // Both a level and a duration are needed before swing is cut
  wire deemph_on = (deemph_lvl_o != utd_pkg::LVL_NONE) &&
                   (deemph_dur_o != utd_pkg::DUR_NONE); // R1
  // First bit of a burst has no history and counts as a transition
  wire bit_repeat = have_prev_reg && (hs_bit_i == prev_bit_reg);
  wire cut = bit_repeat && deemph_on; // R2
  wire [2:0] drop_next = cut ? deemph_lvl_o : utd_pkg::LVL_NONE; // R9

  // Per-bit drive decision; cleared whenever HS drive is off, since
  // the swing code only has meaning on a terminated HS link
  always_ff @(posedge clk_i) begin
    if (srst_i || !hs_active_i) begin
      prev_bit_reg <= 1'b0;
      have_prev_reg <= 1'b0; // R8
      full_reg <= 1'b0;
      reduce_reg <= 1'b0;
      drop_reg <= 3'h0;
    end else if (hs_bit_valid_i) begin
      prev_bit_reg <= hs_bit_i;
      have_prev_reg <= 1'b1;
      full_reg <= ~cut; // R3
      reduce_reg <= cut; // R2
      drop_reg <= drop_next;
    end
  end

  assign tx_full_o = full_reg;
  assign tx_reduce_o = reduce_reg;
  assign tx_drop_db_o = drop_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Reserved positions of the swing register stay zero on reads
  property p_rsvd_zero;
    @(posedge clk_i) disable iff (srst_i)
      (ptr == utd_pkg::OFS_CTL2) |-> (rdata[7] == 1'b0 && rdata[3] == 1'b0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // R11
    else $error("reserved bit reads nonzero");

  // Write to the swing register lands on the next cycle
  property p_swing_wr;
    @(posedge clk_i) disable iff (srst_i)
      wr_ctl2 |=> (hs_swing_o == $past(wdata[2:0]) &&
                   hs_slew_o == $past(wdata[5:4]));
  endproperty
  a_swing_wr: assert property (p_swing_wr) // R4
    else $error("swing register write lost");

  // Fast FS edge is selected after reset
  property p_fs_rst;
    @(posedge clk_i) (!srst_i && $past(srst_i)) |-> fs_fast_edge_o;
  endproperty
  a_fs_rst: assert property (p_fs_rst) // R5
    else $error("fs edge reset value wrong");

  // HS slew resets to code 10
  property p_slew_rst;
    @(posedge clk_i) (!srst_i && $past(srst_i)) |-> (hs_slew_o == 2'h2);
  endproperty
  a_slew_rst: assert property (p_slew_rst) // R6
    else $error("hs slew reset value wrong");

  // Swing resets to 450 mV code
  property p_swing_rst;
    @(posedge clk_i) (!srst_i && $past(srst_i)) |-> (hs_swing_o == 3'h2);
  endproperty
  a_swing_rst: assert property (p_swing_rst) // R7
    else $error("swing reset value wrong");

  // A repeated bit with de-emphasis on is cut by the chosen level
  property p_repeat;
    @(posedge clk_i) disable iff (srst_i)
      (hs_active_i && hs_bit_valid_i && bit_repeat && deemph_on)
        ##1 hs_active_i |-> (tx_reduce_o && !tx_full_o &&
                             tx_drop_db_o == $past(deemph_lvl_o));
  endproperty
  a_repeat: assert property (p_repeat) // R2
    else $error("repeated bit not reduced");

  // An alternating bit goes out at full swing
  property p_alt;
    @(posedge clk_i) disable iff (srst_i)
      (hs_active_i && hs_bit_valid_i && have_prev_reg && hs_bit_i != prev_bit_reg)
        ##1 hs_active_i |-> (tx_full_o && !tx_reduce_o && tx_drop_db_o == 3'h0);
  endproperty
  a_alt: assert property (p_alt) // R3
    else $error("transition bit not at full swing");

  // No drive decision stands while HS drive is off
  property p_inactive;
    @(posedge clk_i) disable iff (srst_i)
      !hs_active_i |=> (!tx_reduce_o && !tx_full_o);
  endproperty
  a_inactive: assert property (p_inactive) // R8
    else $error("drive decision outside hs");

  // Level and duration writes land together
  property p_lvl_wr;
    @(posedge clk_i) disable iff (srst_i)
      wr_ctl1 |=> (deemph_lvl_o == $past(wdata[2:0]));
  endproperty
  a_lvl_wr: assert property (p_lvl_wr) // R9
    else $error("de-emphasis level write lost");

  property p_dur_wr;
    @(posedge clk_i) disable iff (srst_i)
      wr_ctl1 |=> (deemph_dur_o == $past(wdata[5:4]));
  endproperty
  a_dur_wr: assert property (p_dur_wr) // R10
    else $error("de-emphasis duration write lost");

  // Zero duration never cuts swing
  property p_dur_none;
    @(posedge clk_i) disable iff (srst_i)
      (deemph_dur_o == 2'h0 && hs_bit_valid_i) |=> !tx_reduce_o;
  endproperty
  a_dur_none: assert property (p_dur_none) // R1
    else $error("swing cut with zero duration");

endmodule : utd_tx_cfg

/* include/utd_pkg.sv */
// Shared constants for the USB2 transmit drive configuration block
package utd_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTL1 = 8'h07; // De-emphasis level and duration
  localparam logic [7:0] OFS_CTL2 = 8'h08; // Slew rates and output swing

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FS_EDGE_BIT = 6; // Full-speed edge select
  localparam int HS_SLEW_LSB = 4; // High-speed slew code, two bits
  localparam int SWING_LSB = 0; // High-speed swing code, three bits
  localparam int DUR_LSB = 4; // De-emphasis duration, two bits
  localparam int LVL_LSB = 0; // De-emphasis level, three bits

  // ----------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL1_MASK = 8'h37; // Bits 7:6 and 3 are reserved
  localparam logic [7:0] CTL2_MASK = 8'h77; // Bits 7 and 3 are reserved
  localparam logic [7:0] CTL1_RST = 8'h00; // No de-emphasis
  localparam logic [7:0] CTL2_RST = 8'h62; // Fast FS edge, slew 10, 450 mV

  // ----------------------------------------------------------------
  // Field codes and serial bit counts
  // ----------------------------------------------------------------
  localparam logic [1:0] DUR_NONE = 2'h0; // Zero de-emphasis duration
  localparam logic [2:0] LVL_NONE = 3'h0; // 0 dB de-emphasis level
  localparam logic [3:0] BITS_PER_BYTE = 4'h8; // Serial bits per byte
  localparam logic [3:0] LAST_TX_BIT = 4'h7; // Count at last sent bit

endpackage : utd_pkg

/* design/utd_i2c_tgt.sv */
// Serial two-wire target that turns bus transfers into register strobes
`timescale 1ns/1ps

module utd_i2c_tgt #(
  parameter logic [6:0] ADDR = 7'h2a // Bus address, arbitrary default
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [7:0] rdata_i,
  output logic sda_oen_o,
  output logic wr_o,
  output logic [7:0] waddr_o,
  output logic [7:0] wdata_o,
  output logic [7:0] ptr_o
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} utd_st_t;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} utd_ph_t;

  utd_st_t st_reg; // Transfer state
  utd_ph_t ph_reg; // Which byte of a write comes next
  logic [2:0] scl_s_reg; // Clock pin synchroniser chain
  logic [2:0] sda_s_reg; // Data pin synchroniser chain
  logic scl_reg; // Filtered clock level
  logic sda_reg; // Filtered data level
  logic [7:0] sh_reg; // Shift register, both directions
  logic [3:0] cnt_reg; // Bit counter
  logic rw_reg; // Read requested in address byte

  // ----------------------------------------------------------------
  // Pin filtering and bus events
  // ----------------------------------------------------------------
  // A level only counts once the second and third stages agree
  wire scl_next = (scl_s_reg[1] == scl_s_reg[2]) ? scl_s_reg[2] : scl_reg;
  wire sda_next = (sda_s_reg[1] == sda_s_reg[2]) ? sda_s_reg[2] : sda_reg;
  wire scl_rise = scl_next & ~scl_reg;
  wire scl_fall = ~scl_next & scl_reg;
  wire bus_start = scl_reg & scl_next & sda_reg & ~sda_next;
  wire bus_stop = scl_reg & scl_next & ~sda_reg & sda_next;
  wire addr_hit = (sh_reg[7:1] == ADDR);
  wire [7:0] ptr_inc = ptr_o + 8'h01;

  // Synchronisers and filtered levels
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_s_reg <= {scl_s_reg[1:0], scl_i};
      sda_s_reg <= {sda_s_reg[1:0], sda_i};
      scl_reg <= scl_next;
      sda_reg <= sda_next;
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  // Data changes on falling clock, is sampled on rising clock
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= ST_IDLE;
      ph_reg <= PH_ADDR;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      sda_oen_o <= 1'b1;
      wr_o <= 1'b0;
      waddr_o <= 8'h00;
      wdata_o <= 8'h00;
      ptr_o <= 8'h00;
    end else begin
      wr_o <= 1'b0;
      if (bus_stop) begin
        st_reg <= ST_IDLE;
        sda_oen_o <= 1'b1;
      end else if (bus_start) begin
        st_reg <= ST_RX;
        ph_reg <= PH_ADDR;
        cnt_reg <= 4'h0;
        sda_oen_o <= 1'b1;
      end else begin
        unique case (st_reg)
          ST_IDLE: begin
            sda_oen_o <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], sda_next};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == utd_pkg::BITS_PER_BYTE) begin
              cnt_reg <= 4'h0;
              st_reg <= ST_ACK;
              sda_oen_o <= 1'b0;
              unique case (ph_reg)
                PH_ADDR: begin
                  rw_reg <= sh_reg[0];
                  // Foreign address: stay silent until the next start
                  if (!addr_hit) begin
                    st_reg <= ST_IDLE;
                    sda_oen_o <= 1'b1;
                  end
                end
                PH_PTR: begin
                  ptr_o <= sh_reg;
                end
                PH_DATA: begin
                  wr_o <= 1'b1;
                  waddr_o <= ptr_o;
                  wdata_o <= sh_reg;
                  ptr_o <= ptr_inc;
                end
                default: begin
                  st_reg <= ST_IDLE;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (ph_reg == PH_ADDR && rw_reg) begin
                st_reg <= ST_TX;
                sh_reg <= rdata_i;
                sda_oen_o <= rdata_i[7];
              end else begin
                st_reg <= ST_RX;
                sda_oen_o <= 1'b1;
                ph_reg <= (ph_reg == PH_ADDR) ? PH_PTR : PH_DATA;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_reg == utd_pkg::LAST_TX_BIT) begin
                st_reg <= ST_RACK;
                sda_oen_o <= 1'b1;
              end else begin
                sh_reg <= {sh_reg[6:0], 1'b0};
                sda_oen_o <= sh_reg[6];
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            // Controller answers: low asks for more, high ends the read
            if (scl_rise) begin
              if (sda_next) begin
                st_reg <= ST_IDLE;
              end else begin
                ptr_o <= ptr_inc;
              end
            end else if (scl_fall) begin
              st_reg <= ST_TX;
              sh_reg <= rdata_i;
              sda_oen_o <= rdata_i[7];
              cnt_reg <= 4'h0;
            end
          end
        endcase
      end
    end
  end

endmodule : utd_i2c_tgt

/* testbench/utd_i2c_host_model.sv */
// Two-wire bus controller model that programs the block's registers
`timescale 1ns/1ps

module utd_i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h2a // Target address, arbitrary default
) (
  input wire logic clk_i,
  input wire logic sda_i, // Resolved wire level
  output logic scl_o,
  output logic sda_oen_o // Low pulls the wire low
);
  // ------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------
  localparam int HALF = 6; // Clocks per phase, above the 4 the target needs

  initial begin
    scl_o = 1'b1;
    sda_oen_o = 1'b1;
  end

  // Every change lands just after a rising edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_clk

  // Also serves as repeated start: data is raised while the clock is low
  task automatic start_cond;
    sda_oen_o = 1'b1;
    wait_clk(HALF);
    scl_o = 1'b1;
    wait_clk(HALF);
    sda_oen_o = 1'b0;
    wait_clk(HALF);
    scl_o = 1'b0;
    wait_clk(HALF);
  endtask : start_cond

  task automatic stop_cond;
    sda_oen_o = 1'b0;
    wait_clk(HALF);
    scl_o = 1'b1;
    wait_clk(HALF);
    sda_oen_o = 1'b1;
    wait_clk(HALF);
  endtask : stop_cond

  // Data held two clocks past the clock fall so the filters never see it move first
  task automatic xfer_bit(input logic b, output logic r);
    sda_oen_o = b;
    wait_clk(HALF);
    scl_o = 1'b1;
    wait_clk(HALF);
    r = sda_i;
    scl_o = 1'b0;
    wait_clk(2);
  endtask : xfer_bit

  // Byte out MSB first, then the target's acknowledge bit (1 = refused)
  task automatic xfer_byte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(b[i], r);
    xfer_bit(1'b1, nak);
  endtask : xfer_byte

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  // Callers also send codes with reserved bits set
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] data, output logic nak);
    logic n0, n1, n2;
    start_cond();
    xfer_byte({dev, 1'b0}, n0);
    xfer_byte(ofs, n1);
    xfer_byte(data, n2);
    stop_cond();
    nak = n0 | n1 | n2;
  endtask : write_reg

  // Single byte read; the controller ends it with a refusal
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data, output logic nak);
    logic n0, n1, n2, r;
    start_cond();
    xfer_byte({ADDR, 1'b0}, n0);
    xfer_byte(ofs, n1);
    start_cond();
    xfer_byte({ADDR, 1'b1}, n2);
    for (int i = 7; i >= 0; i--) xfer_bit(1'b1, data[i]);
    xfer_bit(1'b1, r);
    stop_cond();
    nak = n0 | n1 | n2;
  endtask : read_reg
endmodule : utd_i2c_host_model

/* testbench/usb2_tx_drive_config_tb_top.sv */
// Self-checking bench for the transmit drive configuration block
`timescale 1ns/1ps

module usb2_tx_drive_config_tb_top;
  localparam logic [6:0] DEV = 7'h2a; // Arbitrary bus address
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic hs_active_i = 1'b0;
  logic hs_bit_i = 1'b0;
  logic hs_bit_valid_i = 1'b0;
  logic scl, host_oen, dut_oen, fs_fast, full, reduce;
  logic [1:0] slew, dur;
  logic [2:0] swing, lvl, drop;
  wire sda = host_oen & dut_oen; // Pulled up, either side may pull low
  int mismatches = 0;
  int checked = 0;

  always #5 clk_i = ~clk_i;

  utd_tx_cfg #(.I2C_ADDR(DEV)) utd_tx_cfg_i (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_oen_o(dut_oen),
    .hs_active_i(hs_active_i), .hs_bit_i(hs_bit_i), .hs_bit_valid_i(hs_bit_valid_i),
    .fs_fast_edge_o(fs_fast), .hs_slew_o(slew), .hs_swing_o(swing),
    .deemph_lvl_o(lvl), .deemph_dur_o(dur), .tx_full_o(full),
    .tx_reduce_o(reduce), .tx_drop_db_o(drop));

  utd_i2c_host_model #(.ADDR(DEV)) utd_i2c_host_model_i (
    .clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oen_o(host_oen));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic end_of_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Writes to the own address must be acknowledged
  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] data);
    logic nak;
    utd_i2c_host_model_i.write_reg(DEV, ofs, data, nak);
    cmp_val({7'h00, nak}, 8'h00);
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    logic nak;
    utd_i2c_host_model_i.read_reg(ofs, d, nak);
    cmp_val({7'h00, nak}, 8'h00);
    cmp_val(d, exp);
  endtask : reg_chk

  // One bit per cycle; the outputs answer at the next edge
  task automatic send_bit(input logic b, input logic rep, input logic [2:0] l, input logic de);
    hs_active_i = 1'b1;
    hs_bit_valid_i = 1'b1;
    hs_bit_i = b;
    @(posedge clk_i);
    #1;
    if (rep) begin
      cmp_val({7'h00, reduce}, {7'h00, de});
      cmp_val({5'h00, drop}, de ? {5'h00, l} : 8'h00);
    end else begin
      cmp_val({6'h00, full, reduce}, 8'h02);
      cmp_val({5'h00, drop}, 8'h00);
    end
  endtask : send_bit

  // Hang guard: a run this long counts as a failure
  initial begin
    repeat (80000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic nak;
    logic de;
    repeat (6) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    // Reset values at the ports and through the bus
    cmp_val({1'h0, fs_fast, slew, 1'h0, swing}, 8'h62);
    reg_chk(8'h08, 8'h62);
    reg_chk(8'h07, 8'h00);
    // Slew codes 0 to 2, swing codes 0 to 5 and 7; reserved bits set on some writes
    for (int i = 0; i < 7; i++) begin
      v = {i[1], i[0], 2'(i % 3), i[2], (i < 6) ? 3'(i) : 3'h7};
      reg_wr(8'h08, v);
      reg_chk(8'h08, v & 8'h77);
      cmp_val({7'h00, fs_fast}, {7'h00, v[6]});
      cmp_val({6'h00, slew}, {6'h00, v[5:4]});
      cmp_val({5'h00, swing}, {5'h00, v[2:0]});
    end
    // Foreign address is refused and changes nothing
    utd_i2c_host_model_i.write_reg(DEV ^ 7'h01, 8'h08, 8'h00, nak);
    cmp_val({7'h00, nak}, 8'h01);
    // Last loop pass wrote 8'h8f; only the writable bits remain
    reg_chk(8'h08, 8'h07);
    // Unmapped offset ignores writes and reads zero
    reg_wr(8'h09, 8'h5a);
    reg_chk(8'h09, 8'h00);
    // Levels 0 to 6 with durations cycling; zero duration keeps full swing
    for (int l = 0; l < 7; l++) begin
      v = {2'h3, 2'(l % 3), 1'h1, 3'(l)};
      reg_wr(8'h07, v);
      reg_chk(8'h07, v & 8'h37);
      cmp_val({5'h00, lvl}, 8'(l));
      cmp_val({6'h00, dur}, 8'(l % 3));
      de = (l != 0) && (l % 3 != 0);
      send_bit(1'b1, 1'b0, 3'(l), de);
      send_bit(1'b1, 1'b1, 3'(l), de);
      send_bit(1'b0, 1'b0, 3'(l), de);
      send_bit(1'b0, 1'b1, 3'(l), de);
      // Dropping the active level clears the outputs and the history
      hs_active_i = 1'b0;
      @(posedge clk_i);
      #1;
      cmp_val({5'h00, full, reduce, |drop}, 8'h00);
      send_bit(1'b0, 1'b0, 3'(l), de);
      hs_active_i = 1'b0;
      hs_bit_valid_i = 1'b0;
    end
    end_of_test();
  end
endmodule : usb2_tx_drive_config_tb_top
